// >>> rtl/smpc_pkg.sv
// smpc_pkg: constants, enums and carrier structs of the sleep mode power controller
// assumes: one 250 MHz system clock; registers reached over APB with 32-bit data
package smpc_pkg;

    localparam int unsigned CLK_MHZ = 250;

    // register byte addresses
    localparam logic [7:0] CORE_CTRL_ADDR  = 8'h00;
    localparam logic [7:0] CLK_GATE_ADDR   = 8'h04;
    localparam logic [7:0] ANALOG_CTL_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR     = 8'h0C;

    // core_control_register fields
    localparam int unsigned CC_OFF_BIT    = 7;
    localparam int unsigned CC_PERMIT_BIT = 5;
    localparam int unsigned CC_KIND_LSB   = 3;
    localparam int unsigned CC_UNLOCK_BIT = 2;

    // analog control fields
    localparam int unsigned AN_CONV_EN_BIT = 0;
    localparam int unsigned AN_COMP_OFF    = 1;
    localparam int unsigned AN_COMP_REF    = 2;
    localparam int unsigned AN_BOD_FUSE    = 3;
    localparam int unsigned AN_XTAL_BIT    = 4;

    localparam int unsigned GATE_BITS = 4;
    localparam int unsigned GATE_CONV = 0;

    // timing counts
    localparam int unsigned UNLOCK_WIN_CYC = 4;
    localparam int unsigned OFF_DELAY_CYC  = 3;
    localparam int unsigned OFF_HOLD_CYC   = 3;
    localparam int unsigned WAKE_HOLD_CYC  = 4;
    localparam int unsigned STANDBY_CYC    = 6;
    localparam int unsigned BOD_WAKE_NS    = 60000;
    localparam int unsigned BOD_WAKE_CYC   = (BOD_WAKE_NS * CLK_MHZ) / 1000;
    localparam int unsigned START_CYC      = 16;

    typedef enum logic [1:0] {
        SK_IDLE,
        SK_CONV_QUIET,
        SK_POWER_DOWN,
        SK_STANDBY
    } smpc_kind_t;

    // clock domain enables toward the clock tree
    typedef struct packed {
        logic core;
        logic progMem;
        logic io;
        logic conv;
        logic fastPer;
        logic osc;
    } smpc_clk_t;

    // wake requests from the rest of the device
    typedef struct packed {
        logic convDone;
        logic storeReady;
        logic extLevel0;
        logic extLevel1;
        logic extEdge;
        logic pinChange;
        logic watchdogIrq;
        logic otherIrq;
    } smpc_wake_t;

endpackage

// >>> rtl/smpc_ctrl.sv
// smpc_ctrl: sleep entry, clock domain gating, wake sequencing and peripheral gating
// assumes: core pulses haltReq one cycle on a halt instruction; resets of the core
// (external, watchdog, brown-out) reach reset_n, so a reset in sleep restarts all
//
// Design decisions made here: the address map and the APB register port.
module smpc_ctrl #(
    parameter int unsigned BOD_WAKE = smpc_pkg::BOD_WAKE_CYC,
    parameter int unsigned START_UP = smpc_pkg::START_CYC
) (
    input  wire logic                clk_sys,      // system clock
    input  wire logic                reset_n,      // async reset
    input  wire logic                psel,         // apb select
    input  wire logic                penable,      // apb enable
    input  wire logic                pwrite,       // apb direction
    input  wire logic [7:0]          paddr,        // apb address
    input  wire logic [31:0]         pwdata,       // apb write data
    output logic      [31:0]         prdata,       // apb read data
    output logic                     pready,       // apb ready
    output logic                     pslverr,      // apb error
    input  wire logic                haltReq,      // halt instruction pulse
    input  wire smpc_pkg::smpc_wake_t wakeIn,      // wake requests
    output smpc_pkg::smpc_clk_t      clkEn,        // clock domain enables
    output logic [smpc_pkg::GATE_BITS-1:0] perClkEn, // peripheral clock enables
    output logic                     perAccessOk, // io register access allowed, one flag, high only while no peripheral is gated
    output logic                     coreHold,     // core stalled
    output logic                     irqResume,    // pulse: run interrupt then resume
    output logic                     convStart,    // pulse: auto conversion
    output logic                     convExtended, // next conversion extended
    output logic                     bodOn,        // brownout detector enable
    output logic                     compOn,       // comparator enable
    output logic                     refOn         // voltage reference enable
);

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_START,
        ST_HOLD
    } state_t;

    state_t      stateReg;
    state_t      stateNext;
    logic [7:0]  coreCtrlReg;
    logic [smpc_pkg::GATE_BITS-1:0] gateReg;
    logic [4:0]  analogReg;
    logic [1:0]  kindReg;
    logic        bodCutReg;
    logic [2:0]  unlockCntReg;
    logic [2:0]  offAgeReg;
    logic        offPendReg;
    logic [31:0] waitCntReg;
    logic [31:0] waitCntNext;
    logic        convPrevReg;

    // ---- apb decode
    wire         apbWr     = psel && penable && pwrite;
    wire         apbRd     = psel && penable && !pwrite;
    wire         hitCore   = (paddr == smpc_pkg::CORE_CTRL_ADDR);
    wire         hitGate   = (paddr == smpc_pkg::CLK_GATE_ADDR);
    wire         hitAnalog = (paddr == smpc_pkg::ANALOG_CTL_ADDR);
    wire         hitStatus = (paddr == smpc_pkg::STATUS_ADDR);
    wire         hitAny    = hitCore || hitGate || hitAnalog || hitStatus;
    wire         wrCore    = apbWr && hitCore;
    wire         wdOff     = pwdata[smpc_pkg::CC_OFF_BIT];
    wire         wdUnlock  = pwdata[smpc_pkg::CC_UNLOCK_BIT];

    wire         armWrite  = wrCore && wdOff && wdUnlock;
    wire         unlockOpen = (unlockCntReg != 3'h0);
    wire         offWrite  = wrCore && wdOff && !wdUnlock && unlockOpen;
    // active between three and six cycles after set
    wire         offActive = offPendReg && (offAgeReg >= 3'(smpc_pkg::OFF_DELAY_CYC));

    wire         permit    = coreCtrlReg[smpc_pkg::CC_PERMIT_BIT];
    wire [1:0]   kindSel   = coreCtrlReg[smpc_pkg::CC_KIND_LSB +: 2];
    wire         xtalSel   = analogReg[smpc_pkg::AN_XTAL_BIT];
    wire         convEn    = analogReg[smpc_pkg::AN_CONV_EN_BIT];
    wire         compOffSw = analogReg[smpc_pkg::AN_COMP_OFF];
    wire         compRef   = analogReg[smpc_pkg::AN_COMP_REF];
    wire         bodFuse   = analogReg[smpc_pkg::AN_BOD_FUSE];
    wire         asleep    = (stateReg == ST_SLEEP);
    wire         deepKind  = kindReg[1];

    wire         sleepGo   = (stateReg == ST_RUN) && haltReq && permit;

    // standby needs crystal clock option, else power down
    function automatic logic [1:0] resolve_kind(input logic [1:0] sel, input logic xtal);
        resolve_kind = (sel == 2'(smpc_pkg::SK_STANDBY) && !xtal)
                     ? 2'(smpc_pkg::SK_POWER_DOWN) : sel;
    endfunction

    // ---- wake selection per mode
    // quiet converter wake set
    wire wakeQuiet = wakeIn.convDone || wakeIn.storeReady || wakeIn.extLevel0
                   || wakeIn.extLevel1 || wakeIn.pinChange || wakeIn.watchdogIrq;
    wire wakeDeep  = wakeIn.extLevel0 || wakeIn.extLevel1 || wakeIn.pinChange
                   || wakeIn.watchdogIrq;
    wire wakeIdle  = wakeQuiet || wakeIn.extEdge || wakeIn.otherIrq;
    wire wakeHit   = (kindReg == 2'(smpc_pkg::SK_IDLE))       ? wakeIdle  :
                     (kindReg == 2'(smpc_pkg::SK_CONV_QUIET)) ? wakeQuiet : wakeDeep;

    // stretched start while detector was cut
    wire [31:0] startLen = bodCutReg ? 32'(BOD_WAKE) :
                           (kindReg == 2'(smpc_pkg::SK_STANDBY)) ? 32'(smpc_pkg::STANDBY_CYC)
                                                                  : 32'(START_UP);
    wire waitDone = (waitCntReg <= 32'h0000_0001);

    always_comb
    begin
        stateNext   = stateReg;
        waitCntNext = (waitCntReg != 32'h0) ? waitCntReg - 32'h1 : 32'h0;
        case (stateReg)
            ST_RUN:
            begin
                if (sleepGo)
                    stateNext = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (wakeHit)
                begin
                    stateNext   = (kindReg == 2'(smpc_pkg::SK_IDLE)) ? ST_HOLD : ST_START;
                    waitCntNext = (kindReg == 2'(smpc_pkg::SK_IDLE))
                                ? 32'(smpc_pkg::WAKE_HOLD_CYC) : startLen;
                end
            end
            ST_START:
            begin
                // four extra cycles after start up
                if (waitDone)
                begin
                    stateNext   = ST_HOLD;
                    waitCntNext = 32'(smpc_pkg::WAKE_HOLD_CYC);
                end
            end
            ST_HOLD:
            begin
                if (waitDone)
                    stateNext = ST_RUN;
            end
            default:
                stateNext = ST_RUN;
        endcase
    end

    // any reset returns the sequencer to run
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stateReg   <= ST_RUN;
            waitCntReg <= 32'h0;
            kindReg    <= 2'h0;
            bodCutReg  <= 1'b0;
        end
        else
        begin
            stateReg   <= stateNext;
            waitCntReg <= waitCntNext;
            if (sleepGo)
                kindReg <= resolve_kind(kindSel, xtalSel);
            // cut on deep entry while off is active, restored when run resumes
            if (sleepGo)
                bodCutReg <= offActive && kindSel[1];
            else if (stateNext == ST_RUN)
                bodCutReg <= 1'b0;
        end
    end

    // ---- registers; the brownout off bit is never written directly
    wire [7:0] ccWrVal = {1'b0, pwdata[6:3], wdUnlock, pwdata[1:0]};

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            coreCtrlReg <= 8'h00;
            gateReg     <= '0;
            analogReg   <= 5'h00;
        end
        else
        begin
            if (wrCore)
                coreCtrlReg <= ccWrVal;
            if (apbWr && hitGate)
                gateReg <= pwdata[smpc_pkg::GATE_BITS-1:0];
            if (apbWr && hitAnalog)
                analogReg <= pwdata[4:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            unlockCntReg <= 3'h0;
            offPendReg   <= 1'b0;
            offAgeReg    <= 3'h0;
        end
        else
        begin
            if (armWrite)
                unlockCntReg <= 3'(smpc_pkg::UNLOCK_WIN_CYC);
            else if (unlockOpen)
                unlockCntReg <= unlockCntReg - 3'h1;
            // self clear after the active window
            if (offWrite)
            begin
                offPendReg <= 1'b1;
                offAgeReg  <= 3'h1;
            end
            else if (offAgeReg >= 3'(smpc_pkg::OFF_DELAY_CYC + smpc_pkg::OFF_HOLD_CYC))
            begin
                offPendReg <= 1'b0;
                offAgeReg  <= 3'h0;
            end
            else if (offPendReg)
                offAgeReg <= offAgeReg + 3'h1;
        end
    end

    // ---- output decode
    wire inSleep = asleep || (stateReg == ST_START);
    wire isIdle  = kindReg == 2'(smpc_pkg::SK_IDLE);
    wire isQuiet = kindReg == 2'(smpc_pkg::SK_CONV_QUIET);
    wire isStby  = kindReg == 2'(smpc_pkg::SK_STANDBY);
    // core and memories frozen, not cleared, via held clocks
    wire coreRun = (stateReg == ST_RUN);
    wire ioRun   = !inSleep || isIdle;
    // converter clock alive in idle and quiet
    wire convRun = !inSleep || !deepKind;
    // oscillator stops only in power down
    wire oscRun  = !inSleep || !deepKind || isStby;
    wire compAlive = !compOffSw && (!(inSleep && deepKind) || compRef);
    wire convAlive = convEn && !gateReg[smpc_pkg::GATE_CONV];
    wire bodAlive  = bodFuse && !(bodCutReg && inSleep);
    wire [smpc_pkg::GATE_BITS-1:0] perNext = {smpc_pkg::GATE_BITS{ioRun}} & ~gateReg;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clkEn        <= '1;
            perClkEn     <= '1;
            perAccessOk  <= 1'b1;
            coreHold     <= 1'b0;
            irqResume    <= 1'b0;
            convStart    <= 1'b0;
            convExtended <= 1'b1;
            convPrevReg  <= 1'b0;
            bodOn        <= 1'b0;
            compOn       <= 1'b0;
            refOn        <= 1'b0;
        end
        else
        begin
            // idle gates core and program memory only
            clkEn.core    <= coreRun;
            clkEn.progMem <= coreRun;
            clkEn.io      <= ioRun;
            clkEn.conv    <= convRun;
            clkEn.fastPer <= ioRun;
            clkEn.osc     <= oscRun;
            // gated peripherals stop and refuse access
            // clearing the gate restarts from held state
            perClkEn     <= perNext;
            perAccessOk  <= (gateReg == '0);
            coreHold     <= (stateNext != ST_RUN);
            irqResume    <= (stateReg == ST_HOLD) && waitDone;
            // auto conversion on light sleep entry
            convStart    <= sleepGo && !kindSel[1] && convAlive;
            convPrevReg  <= convAlive;
            if (convAlive && !convPrevReg)
                convExtended <= 1'b1;
            else if (convStart)
                convExtended <= 1'b0;
            bodOn        <= bodAlive;
            // comparator off in deep sleep unless referenced
            compOn       <= compAlive;
            refOn        <= bodAlive || (compAlive && compRef) || convAlive;
        end
    end

    // ---- apb read side, zero wait states
    wire [31:0] rdCore   = 32'({offActive, coreCtrlReg[6:0]});
    wire [31:0] rdStatus = 32'({bodCutReg, offPendReg, kindReg, stateReg});
    wire [31:0] rdMux = hitCore   ? rdCore :
                        hitGate   ? 32'(gateReg) :
                        hitAnalog ? 32'(analogReg) :
                        hitStatus ? rdStatus : 32'h0000_0000;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata  <= (psel && !penable && !pwrite) ? rdMux : prdata;
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hitAny;
        end
    end

    // ---- assertions
    // no permit no sleep
    no_permit_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (stateReg == ST_RUN && haltReq && !permit) |=> stateReg == ST_RUN)
        else $error("sleep entered without permit");
    idle_clocks_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (asleep && isIdle) ##1 asleep |-> !clkEn.core && clkEn.io && clkEn.conv)
        else $error("idle clock pattern wrong");
    quiet_clocks_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (asleep && isQuiet) ##1 asleep |-> !clkEn.io && clkEn.conv)
        else $error("quiet clock pattern wrong");
    deep_osc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (asleep && kindReg == 2'(smpc_pkg::SK_POWER_DOWN)) ##1 asleep |-> !clkEn.osc)
        else $error("oscillator running in power down");
    edge_ignored_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (asleep && deepKind && wakeIn.extEdge && !wakeDeep) |=> asleep)
        else $error("edge woke deep sleep");
    hold_four_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(stateReg == ST_HOLD) |-> (stateReg == ST_HOLD)[*4] ##1 stateReg == ST_RUN)
        else $error("hold length wrong");
    off_window_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        offWrite |-> !offActive ##1 !offActive ##1 !offActive ##1 offActive[*4] ##1 !offActive)
        else $error("brownout off timing wrong");
    off_locked_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wrCore && wdOff && !wdUnlock && !unlockOpen && !offPendReg) |=> !offPendReg)
        else $error("off bit set without unlock");
    // reference off when all users off
    ref_users_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!bodOn && !compOn && !convAlive && !$past(convAlive)) |-> !refOn)
        else $error("reference left on");

    wake_idle_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
        asleep && isIdle && wakeHit);
    wake_deep_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
        asleep && deepKind && wakeHit);
    bod_cut_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
        bodCutReg && asleep);

endmodule

// >>> tb/smpc_core_model.sv
// smpc_core_model: processor core stand-in, APB master and halt instruction source
// assumes: controller answers every transfer with pready; shares clk_sys and reset_n
module smpc_core_model (
    input  wire logic        clk_sys, // system clock
    input  wire logic        reset_n, // async reset, unused by the core side
    output logic             psel,    // apb select
    output logic             penable, // apb enable
    output logic             pwrite,  // apb direction
    output logic [7:0]       paddr,   // apb address
    output logic [31:0]      pwdata,  // apb write data
    input  wire logic [31:0] prdata,  // apb read data
    input  wire logic        pready,  // apb ready
    input  wire logic        pslverr, // apb error
    output logic             haltReq  // halt instruction pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        haltReq = 1'b0;
    end

    // request held until pready is sampled high, then released
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic unlockOff(input logic [31:0] low);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, smpc_pkg::CORE_CTRL_ADDR, 32'h84 | low, r, e);
        xfer(1'b1, smpc_pkg::CORE_CTRL_ADDR, 32'h80 | low, r, e);
    endtask

    // pulses haltReq for one cycle; sleep follows only if permit is already set
    task automatic halt();
        @(posedge clk_sys);
        haltReq <= 1'b1;
        @(posedge clk_sys);
        haltReq <= 1'b0;
    endtask
endmodule

// >>> tb/tb.sv
// tb: self-checking bench of the sleep mode power controller
// assumes: shortened start-up and detector wake counts; core stand-in drives APB
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BOD_W = 20;
    localparam int START_W = 4;
    logic                 clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, haltReq;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, rd;
    smpc_pkg::smpc_wake_t wakeIn;
    smpc_pkg::smpc_clk_t  clkEn;
    logic [3:0]           perClkEn, g;
    logic                 perAccessOk, coreHold, irqResume, convStart, convExtended;
    logic                 bodOn, compOn, refOn, convSeen, er;
    int                   num_errors, checks_done, seed, n;

    smpc_ctrl #(.BOD_WAKE(BOD_W), .START_UP(START_W)) smpc_ctrl_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .haltReq(haltReq), .wakeIn(wakeIn), .clkEn(clkEn), .perClkEn(perClkEn),
        .perAccessOk(perAccessOk), .coreHold(coreHold), .irqResume(irqResume),
        .convStart(convStart), .convExtended(convExtended), .bodOn(bodOn),
        .compOn(compOn), .refOn(refOn));
    smpc_core_model smpc_core_model_i (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .haltReq(haltReq));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // auto conversion is a one-cycle pulse, so latch it
    always @(posedge clk_sys)
        if (convStart === 1'b1)
            convSeen <= 1'b1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [5:0] expClk(input logic [1:0] k);
        case (k)
            2'd0: return 6'h0F;
            2'd1: return 6'h05;
            2'd2: return 6'h00;
            default: return 6'h01;
        endcase
    endfunction

    function automatic int expWake(input logic [1:0] k, input logic cut);
        if (k == 2'd0)
            return smpc_pkg::WAKE_HOLD_CYC;
        if (k == 2'd3)
            return smpc_pkg::STANDBY_CYC + smpc_pkg::WAKE_HOLD_CYC;
        return (cut ? BOD_W : START_W) + smpc_pkg::WAKE_HOLD_CYC;
    endfunction

    // latency is counted from the edge that presents the wake request
    task automatic wakeUp(input logic [7:0] w, input int expN);
        @(posedge clk_sys);
        wakeIn <= smpc_pkg::smpc_wake_t'(w);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (irqResume !== 1'b1 && n < 200);
        wakeIn <= '0;
        chk(32'(n >= expN && n <= expN + 3), 32'h1);
    endtask

    task automatic sleepCycle(input logic [1:0] k, input logic refBit);
        logic [7:0] bad;
        bad = (k == 2'd0) ? 8'h00 : (k == 2'd1) ? 8'h09 : 8'hC9;
        smpc_core_model_i.xfer(1'b1, smpc_pkg::ANALOG_CTL_ADDR,
                               {27'h0, 2'b10, refBit, 2'b01}, rd, er);
        smpc_core_model_i.xfer(1'b1, smpc_pkg::CORE_CTRL_ADDR, {26'h0, 1'b1, k, 3'h0}, rd, er);
        convSeen <= 1'b0;
        smpc_core_model_i.halt();
        repeat (3) @(posedge clk_sys);
        chk(clkEn, expClk(k));
        chk(convSeen, k < 2'd2);
        chk(compOn, k < 2'd2 || refBit);
        chk(refOn, 1'b1);
        if (bad != 8'h00)
        begin
            wakeIn <= smpc_pkg::smpc_wake_t'(bad);
            repeat (10) @(posedge clk_sys);
            wakeIn <= '0;
            chk(coreHold, 1'b1);
        end
        wakeUp(($random(seed) & 1) ? 8'h04 : 8'h20, expWake(k, 1'b0));
        repeat (2) @(posedge clk_sys);
        chk({coreHold, clkEn}, 7'h3F);
    endtask

    initial
    begin
        seed = 32'h624E55B1;
        num_errors = 0;
        checks_done = 0;
        reset_n = 1'b0;
        wakeIn = '0;
        convSeen = 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        chk({clkEn, perClkEn, perAccessOk, convExtended, coreHold}, 13'h1FFE);
        smpc_core_model_i.halt();
        repeat (3) @(posedge clk_sys);
        chk({coreHold, clkEn}, 7'h3F);
        smpc_core_model_i.xfer(1'b1, smpc_pkg::CORE_CTRL_ADDR, 32'hA0, rd, er);
        smpc_core_model_i.xfer(1'b0, smpc_pkg::CORE_CTRL_ADDR, 32'h0, rd, er);
        chk(rd, 32'h20);
        smpc_core_model_i.xfer(1'b0, 8'h10, 32'h0, rd, er);
        chk({er, rd}, 33'h100000000);
        for (int i = 0; i < 4; i++)
        begin
            g = (i == 3) ? 4'h0 : 4'($random(seed));
            smpc_core_model_i.xfer(1'b1, smpc_pkg::CLK_GATE_ADDR, {28'h0, g}, rd, er);
            smpc_core_model_i.xfer(1'b0, smpc_pkg::CLK_GATE_ADDR, 32'h0, rd, er);
            chk({perClkEn, perAccessOk, rd[3:0]}, {~g, g == 4'h0, g});
        end
        for (int k = 0; k < 4; k++)
            sleepCycle(2'(k), 1'($random(seed)));
        chk(convExtended, 1'b0);
        // converter off and on again must flag the next conversion as extended
        smpc_core_model_i.xfer(1'b1, smpc_pkg::ANALOG_CTL_ADDR, 32'h18, rd, er);
        smpc_core_model_i.xfer(1'b1, smpc_pkg::ANALOG_CTL_ADDR, 32'h19, rd, er);
        repeat (2) @(posedge clk_sys);
        chk({bodOn, convExtended}, 2'b11);
        smpc_core_model_i.unlockOff(32'h30);
        repeat (2) @(posedge clk_sys);
        smpc_core_model_i.halt();
        repeat (3) @(posedge clk_sys);
        chk({bodOn, compOn}, 2'b00);
        wakeUp(8'h04, expWake(2'd2, 1'b1));
        repeat (2) @(posedge clk_sys);
        chk(bodOn, 1'b1);
        smpc_core_model_i.xfer(1'b1, smpc_pkg::CORE_CTRL_ADDR, 32'h30, rd, er);
        smpc_core_model_i.halt();
        repeat (3) @(posedge clk_sys);
        chk(coreHold, 1'b1);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chk({coreHold, clkEn}, 7'h3F);
        close_out();
    end

    initial
    begin
        #100000;
        num_errors++;
        close_out();
    end
endmodule
